//--- shared/lcg_defs.svh
// What this block does
// - single-port ram: shared address, clocked write, async read
// - dual-port ram: one read/write port, one read port
// - read address separate from write address
// - dual-port copy follows first port's write
// - 16x1 rom per lut, cascades to 128
// - rom contents fixed at configuration
// - 16-bit shift register with clock enable
// - four-bit tap address reads any stage asynchronously
// - shift stages have no set or reset
// - dedicated cascade carries last stage onward
// - chained shifters plus wide muxes give 128 bits
// - mux sizes: 2:1, 4:1, 8:1, 16:1, 32:1
// - five-input mux per slice, six/seven/eight levels
// - two upward carry chains, two bits per slice
// - xor for adder, and gate for products
// - or chain joins previous or and carry
// - luts and carry muxes form wide and
// - two bus drivers, own data and control
// - bus drivers are and-or, not tristate
// - four horizontal lines, two per driver, segmentable
// - ram write enable from slice set/reset, shared clock
`ifndef LCG_DEFS_SVH
`define LCG_DEFS_SVH
`define LCG_LUTS     8
`define LCG_SLICES   4
`define LCG_DEPTH    16
`define LCG_AW       4
`define LCG_TOP_BIT  15
`define LCG_ROM_BITS 128
`define LCG_LINES    4
`define LCG_DRIVERS  2
`endif

//--- shared/lcg_pkg.sv
package lcg_pkg;
  typedef enum logic [1:0] {
    LCG_RAM_SP = 2'h0,
    LCG_RAM_DP = 2'h1,
    LCG_SHIFT  = 2'h3,
    LCG_ROM    = 2'h2
  } lcg_mode_t;
endpackage

//--- rtl/lcg_logic_group.sv
`timescale 1ns/1ps
`include "lcg_defs.svh"
module lcg_logic_group #(
  parameter logic [`LCG_ROM_BITS-1:0] ROM_INIT = 128'h0
) (
  input  wire logic                               mclk_i,
  input  wire logic                               rst_n_i,
  input  wire lcg_pkg::lcg_mode_t                 lut_mode_i,
  input  wire logic [`LCG_LUTS-1:0][`LCG_AW-1:0]  lut_read_address_i,
  input  wire logic [`LCG_LUTS-1:0][`LCG_AW-1:0]  lut_write_address_i,
  input  wire logic [`LCG_LUTS-1:0]               ram_wdata_i,
  input  wire logic [`LCG_SLICES-1:0]             slice_set_reset_input_i,
  input  wire logic [`LCG_SLICES-1:0]             shift_ce_i,
  input  wire logic [`LCG_LUTS-1:0]               shift_din_i,
  input  wire logic [`LCG_LUTS-1:0]               shift_cascade_en_i,
  input  wire logic [`LCG_SLICES-1:0]             five_sel_i,
  input  wire logic [`LCG_SLICES-1:0]             upper_sel_i,
  input  wire logic                               far_group_mux_i,
  input  wire logic [1:0]                         carry_cin_i,
  input  wire logic [`LCG_LUTS-1:0]               carry_di_i,
  input  wire logic [`LCG_LUTS-1:0]               mult_a_i,
  input  wire logic [`LCG_LUTS-1:0]               mult_b_i,
  input  wire logic [`LCG_LUTS-1:0]               mult_sel_i,
  input  wire logic [1:0]                         sop_in_i,
  input  wire logic [`LCG_DRIVERS-1:0]            bus_data_i,
  input  wire logic [`LCG_DRIVERS-1:0]            bus_drive_i,
  input  wire logic [`LCG_DRIVERS-1:0]            bus_line_sel_i,
  input  wire logic [`LCG_LINES-1:0]              hline_in_i,
  input  wire logic [`LCG_LINES-1:0]              hline_seg_i,
  output logic      [`LCG_LUTS-1:0]               lut_out_o,
  output logic      [`LCG_LUTS-1:0]               slice_ff_q_o,
  output logic                                    shift_cascade_o,
  output logic      [`LCG_SLICES-1:0]             five_input_wide_mux_o,
  output logic      [1:0]                         six_input_wide_mux_o,
  output logic                                    seven_input_mux_o,
  output logic                                    upper_level_wide_mux_o,
  output logic      [1:0]                         carry_cout_o,
  output logic      [`LCG_LUTS-1:0]               sum_o,
  output logic      [`LCG_LUTS-1:0]               partial_product_o,
  output logic      [1:0]                         sop_chain_o,
  output logic      [`LCG_LINES-1:0]              hline_o
);

  typedef struct packed {
    logic [`LCG_LUTS-1:0][`LCG_DEPTH-1:0] mem;
    logic [`LCG_LUTS-1:0]                 ffq;
  } lcg_state_t;

  lcg_state_t st_r;
  lcg_state_t st_nxt;

  function automatic logic lcg_bit_at(input logic [`LCG_DEPTH-1:0] w,
                                      input logic [`LCG_AW-1:0] a);
    lcg_bit_at = w[a];
  endfunction

  // carry_select_mux: propagate passes carry in, otherwise the generate term
  function automatic logic lcg_carry_mux(input logic prop,
                                         input logic ci,
                                         input logic di);
    lcg_carry_mux = prop ? ci : di;
  endfunction

  logic                                 mode_sp;
  logic                                 mode_dp;
  logic                                 mode_rom;
  logic                                 mode_sh;
  logic [`LCG_LUTS-1:0][`LCG_AW-1:0]    raddr;
  logic [`LCG_LUTS-1:0]                 lut_out;
  logic [`LCG_LUTS-1:0]                 co;
  logic [`LCG_LUTS-1:0]                 ci;
  logic [`LCG_LUTS-1:0]                 di;
  logic [`LCG_DEPTH-2:0]                lut0_low;
  logic                                 lut6_top;

  assign mode_sp  = (lut_mode_i == lcg_pkg::LCG_RAM_SP);
  assign mode_dp  = (lut_mode_i == lcg_pkg::LCG_RAM_DP);
  assign mode_rom = (lut_mode_i == lcg_pkg::LCG_ROM);
  assign mode_sh  = (lut_mode_i == lcg_pkg::LCG_SHIFT);
  assign lut0_low = st_r.mem[0][`LCG_TOP_BIT-1:0];
  assign lut6_top = st_r.mem[6][`LCG_TOP_BIT];

  // read side: all reads are combinational, from the stored bits or from ROM_INIT in rom mode
  always_comb
  begin
    for (int k = 0; k < `LCG_LUTS; k++)
    begin
      if (mode_sp || (mode_dp && (k % 2 == 0)))
        raddr[k] = lut_write_address_i[k];
      else
        raddr[k] = lut_read_address_i[k];
      if (mode_rom)
        lut_out[k] = ROM_INIT[k*`LCG_DEPTH + int'(raddr[k])];
      else
        lut_out[k] = lcg_bit_at(st_r.mem[k], raddr[k]);
    end
  end

  // state update: ram writes, shifting, and the slice flip-flops
  always_comb
  begin
    int src;
    src = 0;
    st_nxt = st_r;
    for (int k = 0; k < `LCG_LUTS; k++)
    begin
      src = (mode_dp && (k % 2 == 1)) ? k - 1 : k;
      if ((mode_sp || mode_dp) && slice_set_reset_input_i[k/2])
        st_nxt.mem[k][lut_write_address_i[src]] = ram_wdata_i[src];
      else if (mode_sh && shift_ce_i[k/2])
      begin
        // stage 15 of the lower lut feeds stage 0 through the dedicated path
        if (k > 0 && shift_cascade_en_i[k])
          st_nxt.mem[k] = {st_r.mem[k][`LCG_TOP_BIT-1:0],
                           st_r.mem[k-1][`LCG_TOP_BIT]};
        else
          st_nxt.mem[k] = {st_r.mem[k][`LCG_TOP_BIT-1:0], shift_din_i[k]};
      end
    end
    // synchronous read copy: only meaningful with a steady tap address
    st_nxt.ffq = lut_out;
  end

  // the lut contents deliberately ignore reset: shift stages have no reset path
  always_ff @(posedge mclk_i)
  begin
    st_r.mem <= st_nxt.mem;
    if (!rst_n_i)
      st_r.ffq <= '0;
    else
      st_r.ffq <= st_nxt.ffq;
  end

  shift_hold_top_a : assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    (mode_sh && !shift_ce_i[3]) |=>
      $stable(st_r.mem[7]))
    else $error("top shift stages moved without enable");

  rom_refuse_a : assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    (mode_rom && slice_set_reset_input_i[3]) |=>
      $stable(st_r.mem[7]))
    else $error("rom mode accepted a ram write");

  ff_copy_a : assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    mode_rom |=>
      (slice_ff_q_o[1] == $past(lut_out_o[1])))
    else $error("slice flop did not copy lut output");

  assign lut_out_o       = lut_out;
  assign slice_ff_q_o    = st_r.ffq;
  assign shift_cascade_o = st_r.mem[`LCG_LUTS-1][`LCG_TOP_BIT];

  // wide mux tree: f5 per slice, two f6, one f7, f8 reaches the next group
  always_comb
  begin
    for (int s = 0; s < `LCG_SLICES; s++)
      five_input_wide_mux_o[s] = five_sel_i[s] ? lut_out[2*s+1] : lut_out[2*s];
    six_input_wide_mux_o[0] = upper_sel_i[0] ? five_input_wide_mux_o[1]
                                             : five_input_wide_mux_o[0];
    six_input_wide_mux_o[1] = upper_sel_i[2] ? five_input_wide_mux_o[3]
                                             : five_input_wide_mux_o[2];
    seven_input_mux_o = upper_sel_i[1] ? six_input_wide_mux_o[1]
                                       : six_input_wide_mux_o[0];
    upper_level_wide_mux_o = upper_sel_i[3] ? far_group_mux_i
                                            : seven_input_mux_o;
  end


  // one level at a time, so a wrong select shows which stage broke
  five_mux_a : assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    (five_sel_i[0] && lut_out_o[1]) |->
      five_input_wide_mux_o[0])
    else $error("five-input mux missed odd lut");

  six_mux_a : assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    (upper_sel_i[0] && five_input_wide_mux_o[1]) |->
      six_input_wide_mux_o[0])
    else $error("six-input mux missed upper slice");

  seven_mux_a : assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    (upper_sel_i[1] && six_input_wide_mux_o[1]) |->
      seven_input_mux_o)
    else $error("seven-input mux missed upper pair");

  upper_far_a : assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    (upper_sel_i[3] && far_group_mux_i) |->
      upper_level_wide_mux_o)
    else $error("eight-input mux missed far group");

  // two upward chains: luts 0..3 (slices 0,1) and luts 4..7 (slices 2,3)
  always_comb
  begin
    for (int k = 0; k < `LCG_LUTS; k++)
    begin
      partial_product_o[k] = mult_a_i[k] & mult_b_i[k];
      di[k] = mult_sel_i[k] ? partial_product_o[k] : carry_di_i[k];
      if (k % 4 == 0)
        ci[k] = carry_cin_i[k/4];
      else
        ci[k] = co[k-1];
      co[k] = lcg_carry_mux(lut_out[k], ci[k], di[k]);
      sum_o[k] = lut_out[k] ^ ci[k];
    end
    carry_cout_o[0] = co[3];
    carry_cout_o[1] = co[7];
  end


  pp_gate_a : assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    1'b1 |->
      (partial_product_o == (mult_a_i & mult_b_i)))
    else $error("partial product gate wrong");

  sum_xor_a : assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    !lut_out_o[0] |->
      (sum_o[0] == carry_cin_i[0]))
    else $error("adder xor did not pass carry in");

  carry_gen_a : assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    (lut_out_o[7:4] == 4'h0) |->
      (carry_cout_o[1] == (mult_sel_i[7] ? partial_product_o[7] : carry_di_i[7])))
    else $error("carry chain top did not take generate term");

  // row 0 holds slices 0 and 2, row 1 slices 1 and 3; top carry is co[2s+1]
  always_comb
  begin
    for (int r = 0; r < 2; r++)
      sop_chain_o[r] = sop_in_i[r] | co[2*r+1] | co[2*(r+2)+1];
  end


  sop_row0_a : assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    sop_in_i[0] |->
      sop_chain_o[0])
    else $error("sum-of-products row 0 dropped chain input");

  // and-or bus: timing stays flat however many drivers share a line
  always_comb
  begin
    for (int i = 0; i < `LCG_LINES; i++)
    begin
      hline_o[i] = hline_seg_i[i] & hline_in_i[i];
      if (bus_line_sel_i[i % 2] == logic'(i / 2))
        hline_o[i] = hline_o[i] | (bus_drive_i[i % 2] & bus_data_i[i % 2]);
    end
  end


  bus_low_a : assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    (bus_drive_i[0] && bus_data_i[0] && !bus_line_sel_i[0]) |->
      hline_o[0])
    else $error("driver 0 missed its lower line");

  bus_high_a : assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    (bus_drive_i[0] && bus_data_i[0] && bus_line_sel_i[0]) |->
      hline_o[2])
    else $error("driver 0 missed its upper line");

  seg_join_a : assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    (hline_seg_i[3] && hline_in_i[3]) |->
      hline_o[3])
    else $error("joined segment lost upstream value");

  sp_write_read_a : assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    (mode_sp && slice_set_reset_input_i[0]) |=>
      (!mode_sp || lut_write_address_i[0] != $past(lut_write_address_i[0])
       || lut_out_o[0] == $past(ram_wdata_i[0])))
    else $error("single-port read after write mismatch");

  dp_read_port_a : assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    mode_dp |-> (lut_out_o[1] == st_r.mem[1][lut_read_address_i[1]]
                 && lut_out_o[0] == st_r.mem[0][lut_write_address_i[0]]))
    else $error("dual-port read path wrong");

  dp_copy_write_a : assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    (mode_dp && slice_set_reset_input_i[0]) |=>
      st_r.mem[1][$past(lut_write_address_i[0])] == $past(ram_wdata_i[0]))
    else $error("dual-port copy not written");

  rom_stable_a : assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    (mode_rom && $past(mode_rom)) |-> ($stable(st_r.mem)
      && lut_out_o[0] == ROM_INIT[lut_read_address_i[0]]))
    else $error("rom contents or read changed");

  shift_move_a : assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    (mode_sh && shift_ce_i[0]) |=>
      (st_r.mem[0][`LCG_TOP_BIT:1] == $past(lut0_low)
       && st_r.mem[0][0] == $past(shift_din_i[0])))
    else $error("shift stage did not advance");

  shift_hold_a : assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    (mode_sh && !shift_ce_i[0]) |=> $stable(st_r.mem[0]))
    else $error("shift stages changed without enable");

  shift_cascade_a : assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    (mode_sh && shift_ce_i[3] && shift_cascade_en_i[7]) |=>
      st_r.mem[7][0] == $past(lut6_top))
    else $error("cascade did not carry last stage");

  carry_and_a : assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    (&lut_out_o[3:0]) |-> (carry_cout_o[0] == carry_cin_i[0]))
    else $error("carry chain did not propagate");

  sop_or_a : assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    (sop_in_i[1] || carry_cout_o[0]) |-> sop_chain_o[1])
    else $error("sum-of-products chain dropped a term");

  bus_andor_a : assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    (!bus_drive_i[1] && !hline_seg_i[1]) |-> !hline_o[1])
    else $error("idle bus line not low");
endmodule

//--- test/lcg_user_logic.sv
`timescale 1ns/1ps
module lcg_user_logic (
  input  wire logic       mclk_i,
  input  wire logic       tap_bit_i,
  output logic      [3:0] tap_addr_o,
  output logic            sync_q_o
);
  // tap held still so the flop is a true ninth stage, not a glitchy sample
  assign tap_addr_o = 4'h7;
  always_ff @(posedge mclk_i)
  begin
    sync_q_o <= tap_bit_i;
  end
endmodule

//--- test/tb_lcg_logic_group.sv
`timescale 1ns/1ps
`include "lcg_defs.svh"
module tb_lcg_logic_group;
  localparam logic [127:0] ROM_V = 128'h0123456789ABCDEF_FEDCBA9876543210;
  logic mclk_i = 1'b0;
  logic rst_n_i = 1'b0;
  lcg_pkg::lcg_mode_t lut_mode_i = lcg_pkg::LCG_RAM_SP;
  logic [7:0][3:0] ra = '0;
  logic [7:0][3:0] lut_write_address_i = '0;
  logic [7:0] ram_wdata_i = '0, shift_din_i = '0, shift_cascade_en_i = '0;
  logic [7:0] carry_di_i = '0, mult_a_i = '0, mult_b_i = '0, mult_sel_i = '0;
  logic [3:0] slice_set_reset_input_i = '0, shift_ce_i = '0, five_sel_i = '0;
  logic [3:0] upper_sel_i = '0, hline_in_i = '0, hline_seg_i = '0;
  logic       far_group_mux_i = 1'b0;
  logic [1:0] carry_cin_i = '0, sop_in_i = '0, bus_data_i = '0;
  logic [1:0] bus_drive_i = '0, bus_line_sel_i = '0;
  wire  [7:0][3:0] lut_read_address_i;
  wire  [3:0] tap;
  wire        sync_q;
  logic [7:0] lut_out_o, slice_ff_q_o, sum_o, partial_product_o;
  logic [3:0] five_input_wide_mux_o, hline_o;
  logic [1:0] six_input_wide_mux_o, carry_cout_o, sop_chain_o;
  logic       shift_cascade_o, seven_input_mux_o, upper_level_wide_mux_o;
  int         miscompares = 0, num_checks = 0, cyc = 0;
  logic [20:0] rows [5];
  logic       we;
  logic [3:0] a;
  logic [7:0] d, e, x;
  // lut0 tap belongs to the user logic model, the rest to the bench
  assign lut_read_address_i = {ra[7:1], tap};
  lcg_logic_group #(.ROM_INIT(ROM_V)) lcg_logic_group_inst (.mclk_i, .rst_n_i,
    .lut_mode_i, .lut_read_address_i, .lut_write_address_i, .ram_wdata_i,
    .slice_set_reset_input_i, .shift_ce_i, .shift_din_i, .shift_cascade_en_i,
    .five_sel_i, .upper_sel_i, .far_group_mux_i, .carry_cin_i, .carry_di_i,
    .mult_a_i, .mult_b_i, .mult_sel_i, .sop_in_i, .bus_data_i, .bus_drive_i,
    .bus_line_sel_i, .hline_in_i, .hline_seg_i, .lut_out_o, .slice_ff_q_o,
    .shift_cascade_o, .five_input_wide_mux_o, .six_input_wide_mux_o,
    .seven_input_mux_o, .upper_level_wide_mux_o, .carry_cout_o, .sum_o,
    .partial_product_o, .sop_chain_o, .hline_o);
  lcg_user_logic lcg_user_logic_inst (.mclk_i(mclk_i), .tap_bit_i(lut_out_o[0]),
    .tap_addr_o(tap), .sync_q_o(sync_q));
  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      miscompares++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic stop_test();
    $display("checks=%0d miscompares=%0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge mclk_i);
  endtask
  initial
  begin
    forever #5 mclk_i = ~mclk_i;
  end
  // run needs about 326 cycles
  always @(posedge mclk_i)
  begin
    cyc <= cyc + 1;
    if (cyc == 1000)
    begin
      miscompares++;
      stop_test();
    end
  end
  initial
  begin
    rows = '{{1'b1, 4'h3, 8'hA5, 8'hA5}, {1'b1, 4'h4, 8'h5A, 8'h5A},
             {1'b0, 4'h3, 8'hFF, 8'hA5}, {1'b0, 4'h4, 8'h00, 8'h5A},
             {1'b1, 4'h3, 8'h3C, 8'h3C}};
    tick(11);
    #1 check(slice_ff_q_o, 8'h00);
    tick(1);
    rst_n_i <= 1'b1;
    // lut contents power up unknown; clear them so later reads compare cleanly
    for (int ad = 0; ad < 16; ad++)
    begin
      tick(1);
      slice_set_reset_input_i <= 4'hF;
      lut_write_address_i <= {8{ad[3:0]}};
    end
    $display("clear done");
    foreach (rows[i])
    begin
      {we, a, d, e} = rows[i];
      tick(1);
      slice_set_reset_input_i <= {4{we}};
      lut_write_address_i <= {8{a}};
      ram_wdata_i <= d;
      tick(1);
      slice_set_reset_input_i <= 4'h0;
      #1 check(lut_out_o, e);
      tick(1);
      #1 check(slice_ff_q_o, e);
      $display("ram row %0d done", i);
    end
    tick(1);
    lut_mode_i <= lcg_pkg::LCG_RAM_DP;
    lut_write_address_i <= {8{4'h9}};
    ram_wdata_i <= 8'h01;
    slice_set_reset_input_i <= 4'h1;
    ra[1] <= 4'h9;
    tick(1);
    slice_set_reset_input_i <= 4'h0;
    lut_write_address_i <= {8{4'h3}};
    #1 check(lut_out_o[1:0], 2'h2);
    $display("dual port done");
    tick(1);
    lut_mode_i <= lcg_pkg::LCG_ROM;
    slice_set_reset_input_i <= 4'hF;
    ram_wdata_i <= 8'hFF;
    five_sel_i <= 4'h5;
    upper_sel_i <= 4'h6;
    for (int ad = 0; ad < 16; ad++)
    begin
      tick(1);
      ra <= {8{ad[3:0]}};
      #1 x[0] = ROM_V[7];
      for (int k = 1; k < 8; k++)
        x[k] = ROM_V[16*k+ad];
      check(lut_out_o, x);
      check(five_input_wide_mux_o, {x[6], x[5], x[2], x[1]});
      check({six_input_wide_mux_o, seven_input_mux_o}, {x[6], x[1], x[6]});
      check(upper_level_wide_mux_o, x[6]);
    end
    $display("rom done");
    tick(1);
    slice_set_reset_input_i <= 4'h0;
    lut_mode_i <= lcg_pkg::LCG_SHIFT;
    shift_ce_i <= 4'hF;
    shift_cascade_en_i <= 8'hFE;
    tick(128);
    shift_din_i <= 8'h01;
    tick(1);
    shift_din_i <= 8'h00;
    tick(6);
    #1 check(lut_out_o[0], 1'b0);
    tick(1);
    #1 check(lut_out_o[0], 1'b1);
    tick(1);
    #1 check({sync_q, lut_out_o[0]}, 2'h2);
    tick(118);
    #1 check(shift_cascade_o, 1'b0);
    tick(1);
    shift_ce_i <= 4'h0;
    rst_n_i <= 1'b0;
    #1 check(shift_cascade_o, 1'b1);
    tick(3);
    rst_n_i <= 1'b1;
    #1 check(shift_cascade_o, 1'b1);
    $display("shift done");
    tick(1);
    mult_sel_i <= 8'hFF;
    mult_a_i <= 8'hF0;
    mult_b_i <= 8'h3C;
    sop_in_i <= 2'h3;
    bus_data_i <= 2'h3;
    bus_drive_i <= 2'h3;
    bus_line_sel_i <= 2'h2;
    hline_in_i <= 4'h2;
    hline_seg_i <= 4'h2;
    carry_cin_i <= 2'h3;
    upper_sel_i <= 4'hE;
    far_group_mux_i <= 1'b1;
    tick(1);
    #1 check(partial_product_o, 8'h30);
    check(sop_chain_o, 2'h3);
    check(hline_o, 4'hB);
    check(sum_o, 8'hF1);
    check(carry_cout_o, 2'h0);
    check(upper_level_wide_mux_o, 1'b1);
    tick(1);
    bus_data_i <= 2'h1;
    bus_drive_i <= 2'h2;
    hline_seg_i <= 4'h0;
    tick(1);
    #1 check(hline_o, 4'h0);
    $display("fabric gates done");
    stop_test();
  end
endmodule
